//--- bmmc_map.vh
`ifndef BMMC_MAP_VH
`define BMMC_MAP_VH
`define BMMC_ADDR_LINES_NARROW 5'h10
`define BMMC_ADDR_LINES_WIDE   5'h14
`define BMMC_BOOT_VEC_INT      20'h4_0000
`define BMMC_BOOT_VEC_EXT_NAR  20'h0_0000
`define BMMC_BOOT_VEC_EXT_WIDE 20'h4_0000
`define BMMC_COP_VEC_OFS       20'h0_0002
`define BMMC_PIN_FN_GPIO       4'h0
`define BMMC_PIN_FN_ADDR       4'hF
`define BMMC_CS_LEGACY         1'b1
`define BMMC_BIT_CLEAR         1'b0
`define BMMC_BIT_SET           1'b1
`endif

//--- bmmc_vector_sel.v
`timescale 1ns/1ps
`include "bmmc_map.vh"
module bmmc_vector_sel (
  input  wire        ext_boot,
  input  wire        wide_addr,
  output wire [19:0] reset_vector,
  output wire [19:0] cop_vector
);
  // external narrow boot shadows the bottom of program space
  assign reset_vector = !ext_boot ? `BMMC_BOOT_VEC_INT :
                        (wide_addr ? `BMMC_BOOT_VEC_EXT_WIDE : `BMMC_BOOT_VEC_EXT_NAR);
  assign cop_vector   = reset_vector + `BMMC_COP_VEC_OFS;
endmodule

//--- bmmc_top.v
`timescale 1ns/1ps
`include "bmmc_map.vh"
// What this block does
// - At reset the security bit loads from the flash secured state and the map bit from the boot strap.
// - With both bits zero the chip boots internally, 16 address lines, secured, no external program space, debug off.
// - A strap asking for external boot while secured is rejected and the zero state is used.
// - Security bit one and map bit zero boots internally with 16 address lines.
// - Both bits one boots externally, unsecured, with the wide-address strap choosing the interface width.
// - The security bit is loaded only at reset and ignores later flash state changes.
// - A software write to the security bit changes neither flash security nor the program map.
// - After reset software may write the map bit, zero for internal map and one for external map.
// - If the security bit was zero at reset, map bit writes have no effect on the program map.
// - After reset the first two chip selects act as program and data strobes in legacy mode.
// - In external boot the wide-address strap turns four general pins into address bits 19 to 16, only bit 16 usable.
// - The reset vector depends on the wide-address strap and the boot mode.
// - The boot strap level is caught as the operating mode when reset is released.
// - Wide strap high in external boot gives a 20-bit bus, low gives a 16-bit bus.
module bmmc_top (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        flash_secured_b,
  input  wire        external_boot_strap,
  input  wire        wide_address_strap,
  input  wire        sw_wr_map_select,
  input  wire        sw_wr_security_mode,
  input  wire        sw_wdata,
  input  wire        legacy_cs_clear,
  output reg         map_select_bit,
  output reg         security_mode_bit,
  output reg         external_boot,
  output reg         external_map,
  output reg         flash_unsecured,
  output reg         ext_pspace_allowed,
  output reg         on_chip_debug_unit_en,
  output reg  [4:0]  addr_lines,
  output reg  [3:0]  upper_addr_pin_fn,
  output reg         address_bit_sixteen_en,
  output reg         chip_select_zero_is_program_space_strobe,
  output reg         chip_select_one_is_data_space_strobe,
  output reg  [19:0] reset_vector,
  output reg  [19:0] cop_reset_vector
);
  // one-hot boot mode, captured while reset holds
  localparam [2:0] MODE_INT_LOCKED = 3'h1;
  localparam [2:0] MODE_INT_OPEN   = 3'h2;
  localparam [2:0] MODE_EXT_BOOT   = 3'h4;

  // next_ values are built in the blocks below, registers copy them except the derived outputs under reset
  reg  [2:0]  boot_state;
  reg  [2:0]  next_boot_state;
  reg         wide_latched;
  reg         next_wide_latched;
  reg         next_external_boot;
  reg         next_security_mode_bit;
  reg         next_map_select_bit;
  reg         next_cs_program_strobe;
  reg         next_cs_data_strobe;
  reg         next_external_map;
  reg         next_flash_unsecured;
  reg         next_ext_pspace_allowed;
  reg         next_debug_en;
  reg  [4:0]  next_addr_lines;
  reg  [3:0]  next_upper_addr_pin_fn;
  reg         next_address_bit_sixteen_en;
  reg  [19:0] next_reset_vector;
  reg  [19:0] next_cop_reset_vector;
  wire        mode_ext;
  wire [19:0] vec_rst;
  wire [19:0] vec_cop;

  function ext_granted(input unsecured, input strap);
    ext_granted = unsecured & strap;
  endfunction

  function [2:0] mode_decode(input unsecured, input strap);
    if (ext_granted(unsecured, strap))
      mode_decode = MODE_EXT_BOOT;
    else if (unsecured)
      mode_decode = MODE_INT_OPEN;
    else
      mode_decode = MODE_INT_LOCKED;
  endfunction

  function [4:0] lines_for(input wide);
    lines_for = wide ? `BMMC_ADDR_LINES_WIDE : `BMMC_ADDR_LINES_NARROW;
  endfunction

  function [3:0] pins_for(input wide);
    pins_for = wide ? `BMMC_PIN_FN_ADDR : `BMMC_PIN_FN_GPIO;
  endfunction

  assign mode_ext = ext_granted(flash_secured_b, external_boot_strap);

  // vectors follow the registered mode, so they settle one edge after release
  bmmc_vector_sel u_vec (
    .ext_boot     (external_boot),
    .wide_addr    (wide_latched),
    .reset_vector (vec_rst),
    .cop_vector   (vec_cop)
  );

  // straps are sampled on every clock edge while reset holds; the last one before release wins
  always @* begin
    next_boot_state        = boot_state;
    next_wide_latched      = wide_latched;
    next_external_boot     = external_boot;
    next_security_mode_bit = security_mode_bit;
    next_map_select_bit    = map_select_bit;
    next_cs_program_strobe = chip_select_zero_is_program_space_strobe;
    next_cs_data_strobe    = chip_select_one_is_data_space_strobe;
    if (!rst_b) begin
      next_boot_state        = mode_decode(flash_secured_b, external_boot_strap);
      next_security_mode_bit = flash_secured_b;
      next_map_select_bit    = mode_ext;
      next_external_boot     = mode_ext;
      next_wide_latched      = mode_ext & wide_address_strap;
      next_cs_program_strobe = `BMMC_CS_LEGACY;
      next_cs_data_strobe    = `BMMC_CS_LEGACY;
    end else begin
      if (sw_wr_security_mode) begin
        next_security_mode_bit = sw_wdata;
      end
      if (sw_wr_map_select) begin
        next_map_select_bit = sw_wdata;
      end
      if (legacy_cs_clear) begin
        next_cs_program_strobe = `BMMC_BIT_CLEAR;
        next_cs_data_strobe    = `BMMC_BIT_CLEAR;
      end
    end
  end

  // captured state held
  // no reset branch: the capture block already gives the reset values
  always @(posedge mclk) begin
    boot_state        <= next_boot_state;
    wide_latched      <= next_wide_latched;
    external_boot     <= next_external_boot;
    security_mode_bit <= next_security_mode_bit;
    map_select_bit    <= next_map_select_bit;
    chip_select_zero_is_program_space_strobe <= next_cs_program_strobe;
    chip_select_one_is_data_space_strobe     <= next_cs_data_strobe;
  end

  // enables by mode
  // enables come from the captured code, never from the live flash state
  always @* begin
    next_flash_unsecured    = `BMMC_BIT_CLEAR;
    next_ext_pspace_allowed = `BMMC_BIT_CLEAR;
    next_debug_en           = `BMMC_BIT_CLEAR;
    case (boot_state)
      MODE_INT_OPEN: begin
        next_flash_unsecured    = `BMMC_BIT_SET;
        next_ext_pspace_allowed = `BMMC_BIT_SET;
        next_debug_en           = `BMMC_BIT_SET;
      end
      MODE_EXT_BOOT: begin
        next_flash_unsecured    = `BMMC_BIT_SET;
        next_ext_pspace_allowed = `BMMC_BIT_SET;
        next_debug_en           = `BMMC_BIT_SET;
      end
      MODE_INT_LOCKED: begin
        next_flash_unsecured    = `BMMC_BIT_CLEAR;
        next_ext_pspace_allowed = `BMMC_BIT_CLEAR;
        next_debug_en           = `BMMC_BIT_CLEAR;
      end
      default: begin
        // a corrupt code is treated as secured, never as open
        next_flash_unsecured    = `BMMC_BIT_CLEAR;
        next_ext_pspace_allowed = `BMMC_BIT_CLEAR;
        next_debug_en           = `BMMC_BIT_CLEAR;
      end
    endcase
  end

  always @* begin
    next_external_map           = next_flash_unsecured & map_select_bit;
    next_addr_lines             = lines_for(wide_latched);
    next_upper_addr_pin_fn      = pins_for(wide_latched);
    next_address_bit_sixteen_en = wide_latched;
    next_reset_vector           = vec_rst;
    next_cop_reset_vector       = vec_cop;
  end

  // derived outputs show the locked mode for as long as reset holds
  always @(posedge mclk) begin
    if (!rst_b) begin
      external_map           <= `BMMC_BIT_CLEAR;
      flash_unsecured        <= `BMMC_BIT_CLEAR;
      ext_pspace_allowed     <= `BMMC_BIT_CLEAR;
      on_chip_debug_unit_en  <= `BMMC_BIT_CLEAR;
      addr_lines             <= lines_for(`BMMC_BIT_CLEAR);
      upper_addr_pin_fn      <= pins_for(`BMMC_BIT_CLEAR);
      address_bit_sixteen_en <= `BMMC_BIT_CLEAR;
      reset_vector           <= `BMMC_BOOT_VEC_INT;
      cop_reset_vector       <= `BMMC_BOOT_VEC_INT + `BMMC_COP_VEC_OFS;
    end else begin
      external_map           <= next_external_map;
      flash_unsecured        <= next_flash_unsecured;
      ext_pspace_allowed     <= next_ext_pspace_allowed;
      on_chip_debug_unit_en  <= next_debug_en;
      addr_lines             <= next_addr_lines;
      upper_addr_pin_fn      <= next_upper_addr_pin_fn;
      address_bit_sixteen_en <= next_address_bit_sixteen_en;
      reset_vector           <= next_reset_vector;
      cop_reset_vector       <= next_cop_reset_vector;
    end
  end
endmodule

//--- bmmc_strap_model.sv
`timescale 1ns/1ps
module bmmc_strap_model (
  input  wire [2:0] mode,
  output wire       flash_secured_b,
  output wire       external_boot_strap,
  output wire       wide_address_strap
);
  // software side: strap levels only, no high addresses used
  assign {flash_secured_b, external_boot_strap, wide_address_strap} = mode;
endmodule

//--- bmmc_chk.sv
`timescale 1ns/1ps
module bmmc_chk (
  input wire mclk, rst_b, sw_wr_map_select, sw_wr_security_mode, sw_wdata,
  input wire map_select_bit, security_mode_bit, external_map, external_boot,
  input wire flash_unsecured, on_chip_debug_unit_en,
  input wire [4:0] addr_lines,
  input wire [19:0] reset_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  map_wr_a: assert property (sw_wr_map_select |=> map_select_bit == $past(sw_wdata))
    else $error("map bit write lost");
  sec_hold_a: assert property ($past(rst_b) && !$past(sw_wr_security_mode) |-> $stable(security_mode_bit))
    else $error("security bit moved");
  map_lock_a: assert property (external_map |-> flash_unsecured)
    else $error("external map while secured");
  boot_sec_a: assert property ($past(rst_b) && external_boot |-> flash_unsecured)
    else $error("external boot while secured");
  int_lines_a: assert property (!external_boot |-> addr_lines == 5'h10)
    else $error("internal boot width wrong");
  int_vec_a: assert property (!external_boot |-> reset_vector == 20'h4_0000)
    else $error("internal vector wrong");
  debug_en_a: assert property (on_chip_debug_unit_en == flash_unsecured)
    else $error("debug enable wrong");
  map_set_a: assert property (sw_wr_map_select && sw_wdata && flash_unsecured |=> ##1 external_map)
    else $error("external map not taken");
endmodule
bind bmmc_top bmmc_chk i_chk (.*);

//--- bmmc_top_tb.sv
`timescale 1ns/1ps
module bmmc_top_tb;
  reg         mclk = 0, rst_b = 0, wr_m = 0, wr_s = 0, wd = 0, lc = 0;
  reg  [2:0]  mode = 0;
  integer     bad_count = 0, n_checks = 0, i;
  wire        fs, eb, wa, mb, sb, xb, xm, fu, dbg, ep, a16, cs0, cs1;
  wire [3:0]  pf;
  wire [4:0]  al;
  wire [19:0] rv, cv;
  always #50 mclk = ~mclk;
  bmmc_strap_model i_strap (.mode(mode), .flash_secured_b(fs), .external_boot_strap(eb),
    .wide_address_strap(wa));
  bmmc_top i_dut (.mclk(mclk), .rst_b(rst_b), .flash_secured_b(fs), .external_boot_strap(eb),
    .wide_address_strap(wa), .sw_wr_map_select(wr_m), .sw_wr_security_mode(wr_s),
    .sw_wdata(wd), .legacy_cs_clear(lc), .map_select_bit(mb), .security_mode_bit(sb),
    .external_boot(xb), .external_map(xm), .flash_unsecured(fu), .ext_pspace_allowed(ep),
    .on_chip_debug_unit_en(dbg), .addr_lines(al), .upper_addr_pin_fn(pf),
    .address_bit_sixteen_en(a16), .chip_select_zero_is_program_space_strobe(cs0),
    .chip_select_one_is_data_space_strobe(cs1), .reset_vector(rv), .cop_reset_vector(cv));
  task chk(input [47:0] nm, input [19:0] exp, got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s exp %h got %h", nm, exp, got);
    end
  endtask
  task step(input integer n); repeat (n) @(posedge mclk); #10; endtask
  // straps must settle before the last reset edge
  task boot(input [2:0] m); mode = m; rst_b = 0; step(16); rst_b = 1; step(2); endtask
  task wr(input m, input d); wd = d; wr_m = m; wr_s = !m; step(1); wr_m = 0; wr_s = 0; step(1);
  endtask
  task t_boot;
    for (i = 0; i < 8; i = i + 1) begin
      boot(i);
      chk("extb", i[2] & i[1], xb);
      chk("dbg", i[2], dbg);
      chk("lines", (i[2] & i[1] & i[0]) ? 20'h14 : 20'h10, al);
      chk("vec", (i[2] & i[1] & !i[0]) ? 20'h0_0000 : 20'h4_0000, rv);
      chk("map", i[2] & i[1], mb);
      chk("secb", i[2], sb);
      chk("psp", i[2], ep);
      chk("a16", i[2] & i[1] & i[0], a16);
      chk("pins", (i[2] & i[1] & i[0]) ? 20'hf : 20'h0, pf);
      chk("cop", (i[2] & i[1] & !i[0]) ? 20'h0_0002 : 20'h4_0002, cv);
      chk("cs0", 1, cs0);
      chk("cs1", 1, cs1);
    end
    $display("t_boot done");
  endtask
  task t_write;
    boot(3'b100);
    mode = 0;
    wr(1, 1);
    chk("xmap", 1, xm);
    chk("sec", 1, sb);
    wr(0, 0);
    chk("unsec", 1, fu);
    chk("xmap", 1, xm);
    chk("secw", 0, sb);
    lc = 1;
    step(1);
    lc = 0;
    step(1);
    chk("cs0", 0, cs0);
    chk("cs1", 0, cs1);
    $display("t_write done");
  endtask
  task t_lock;
    boot(3'b010);
    chk("map", 0, mb);
    chk("cs0", 1, cs0);
    wr(1, 1);
    chk("xmap", 0, xm);
    $display("t_lock done");
  endtask
  task t_hold;
    mode = 3'b000;
    rst_b = 0;
    step(8);
    mode = 3'b111;
    step(8);
    rst_b = 1;
    step(2);
    chk("extb", 1, xb);
    mode = 3'b000;
    step(4);
    chk("extb", 1, xb);
    chk("lines", 20'h14, al);
    chk("secb", 1, sb);
    chk("pins", 20'hf, pf);
    $display("t_hold done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin #100000; bad_count = bad_count + 1; conclude; end
  initial begin t_boot; t_write; t_lock; t_hold; conclude; end
endmodule
